// [adc_host_control_port_bench.sv]
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin numErrors++; $display("Error %s exp %h got %h", n, e, g); end end
module adc_host_control_port_bench
   import ahcp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, csN, wrN, oeN, busOeN, sampleEn, pgExt, pwrDn, tAct, ovf;
   logic [ADDR_W-1:0] busAddr;
   logic [DATA_W-1:0] busDin, busDout, rv;
   logic signed [DATA_W:0] diffIn;
   logic [GAIN_W-1:0] gain;
   logic [2:0] tms;
   logic ro;
   int numErrors = 0;
   int checksDone = 0;
   ahcp_top i_dut (.clk_sys(clk_sys), .rst(rst), .busAddr(busAddr), .csN(csN), .wrN(wrN),
      .oeN(oeN), .busDin(busDin), .busDout(busDout), .busOeN(busOeN), .sampleEn(sampleEn),
      .diffIn(diffIn), .gainStage(gain), .bandgapPinExt(pgExt), .powerDown(pwrDn),
      .testModeSelect(tms), .testActive(tAct), .outOfRangeFlag(ovf));
   ahcp_host_model i_host (.clk_sys(clk_sys), .busAddr(busAddr), .csN(csN), .wrN(wrN),
      .oeN(oeN), .busDin(busDin), .busDout(busDout), .busOeN(busOeN));
   task automatic end_sim();
      if (numErrors == 0 && checksDone > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   // Steady input over more pulses than the pipe is deep, so alignment cannot hide a fault
   task automatic conv(input logic signed [DATA_W:0] d, input logic [DATA_W-1:0] e, input logic v);
      @(posedge clk_sys);
      diffIn <= d;
      repeat (PIPE_DEPTH + 2) begin
         @(posedge clk_sys);
         sampleEn <= 1'b1;
         @(posedge clk_sys);
         sampleEn <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      i_host.rd(ADDR_RESULT, rv, ro);
      `CHK("result", e, rv)
      `CHK("range flag", v, ovf)
   endtask : conv
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      numErrors++;
      end_sim();
   end
   initial begin
      rst = 1'b1;
      sampleEn = 1'b0;
      diffIn = '0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      `CHK("idle bus enable", 1'b1, busOeN)
      i_host.wr(ADDR_GAIN, 14'h0005);
      `CHK("gain", 3'h5, gain)
      i_host.rd(ADDR_GAIN, rv, ro);
      `CHK("gain read", 14'h0005, rv)
      `CHK("read bus enable", 1'b0, ro)
      i_host.wr(ADDR_GAIN, 14'h0007);
      `CHK("gain max", 3'h7, gain)
      i_host.wr(ADDR_CONTROL, 14'h1000);
      `CHK("bandgap ext", 1'b1, pgExt)
      i_host.wr(ADDR_CONTROL, 14'h2000);
      `CHK("power down", 1'b1, pwrDn)
      i_host.wr(ADDR_RESULT, 14'h0000);
      i_host.rd(ADDR_CONTROL, rv, ro);
      `CHK("control kept", 14'h2000, rv)
      for (int t = 0; t < 8; t++) begin
         i_host.wr(ADDR_CONTROL, 14'(t) << BIT_TM_LO);
         `CHK("test mode", 3'(t), tms)
         `CHK("test active", 1'(t != 0 && t != 4), tAct)
      end
      i_host.wr(ADDR_CONTROL, 14'h0000);
      conv(15'sd0, 14'h2000, 1'b0);
      conv(15'sd8191, 14'h3fff, 1'b0);
      conv(-15'sd8192, 14'h0000, 1'b0);
      conv(15'sd9000, 14'h3fff, 1'b1);
      i_host.wr(ADDR_OFFSET, 14'h000a);
      conv(15'sd0, 14'h200a, 1'b0);
      conv(15'sd8191, 14'h3fff, 1'b0);
      i_host.wr(ADDR_CONTROL, 14'h0080);
      conv(15'sd0, 14'h2000, 1'b0);
      i_host.wr(ADDR_CONTROL, 14'h0800);
      conv(15'sd0, 14'h000a, 1'b0);
      i_host.wr(ADDR_CONTROL, 14'h0000);
      i_host.wr(ADDR_OFFSET, 14'h0080);
      conv(15'sd0, 14'h1f80, 1'b0);
      conv(-15'sd8150, 14'h0000, 1'b0);
      end_sim();
   end
endmodule : adc_host_control_port_bench
`default_nettype wire

// [ahcp_corrector.sv]
`default_nettype none
module ahcp_corrector
   import ahcp_pkg::*;
(
   // Raw code, straight binary
   input wire logic [DATA_W-1:0] rawCode,
   input wire logic [OFFS_W-1:0] offsetVal,
   input wire logic offDisable,
   input wire logic twosFmt,
   // Result
   output logic [DATA_W-1:0] outCode
);
   logic signed [DATA_W+1:0] sum;
   logic [DATA_W-1:0] clamped;
   // Signed offset sign-extended; disabled when bit set
   assign sum = $signed({2'b00, rawCode})
      + (offDisable ? '0 : (DATA_W+2)'($signed(offsetVal)));
   // Saturate instead of wrapping
   assign clamped = sum < 0 ? CODE_MIN
      : (sum > $signed({2'b00, CODE_MAX}) ? CODE_MAX : sum[DATA_W-1:0]);
   assign outCode = twosFmt ? (clamped ^ MIDSCALE) : clamped;
endmodule : ahcp_corrector
`default_nettype wire

// [ahcp_host_model.sv]
`default_nettype none
module ahcp_host_model
   import ahcp_pkg::*;
(
   // Host bus
   input wire logic clk_sys,
   output logic [ADDR_W-1:0] busAddr,
   output logic csN,
   output logic wrN,
   output logic oeN,
   output logic [DATA_W-1:0] busDin,
   input wire logic [DATA_W-1:0] busDout,
   input wire logic busOeN
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      busAddr = '0;
      csN = 1'b1;
      wrN = 1'b1;
      oeN = 1'b1;
      busDin = '0;
   end
   // Also serves offset calibration writes
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      busAddr <= a;
      busDin <= d;
      csN <= 1'b0;
      wrN <= 1'b0;
      @(posedge clk_sys);
      csN <= 1'b1;
      wrN <= 1'b1;
      // Released data shows no stale value
      busDin <= ~d;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic o);
      @(posedge clk_sys);
      busAddr <= a;
      csN <= 1'b0;
      oeN <= 1'b0;
      @(posedge clk_sys);
      #1;
      d = busDout;
      o = busOeN;
      @(posedge clk_sys);
      csN <= 1'b1;
      oeN <= 1'b1;
   endtask : rd
endmodule : ahcp_host_model
`default_nettype wire

// [ahcp_pkg.sv]
// Summary of operation
// - REF bit 12 set disconnects internal bandgap
// - Gain register selects 0 to 7 dB
// - Flag out of range beyond reference span
// - Flag shares the data pipeline latency
// - Add offset register value when correction enabled
// - Test modes drive fixed internal input voltages
// - Data bus driven only while enable low
// - Full scale at plus/minus span, zero mid
// - Correction bit zero enables, one disables
// - Offset is signed, -128 to 127 LSB
// - Codes 000 and 100 select normal input
// - Format bit: 0 binary, 1 twos complement
`default_nettype none
package ahcp_pkg;
   localparam int DATA_W = 14;
   localparam int ADDR_W = 2;
   localparam int PIPE_DEPTH = 3;
   localparam logic [1:0] ADDR_RESULT = 2'h0;
   localparam logic [1:0] ADDR_GAIN = 2'h1;
   localparam logic [1:0] ADDR_OFFSET = 2'h2;
   localparam logic [1:0] ADDR_CONTROL = 2'h3;
   localparam logic [13:0] RESET_VAL = 14'h0000;
   localparam int GAIN_W = 3;
   localparam int OFFS_W = 8;
   localparam int BIT_PWD = 13;
   localparam int BIT_REF = 12;
   localparam int BIT_FOR = 11;
   localparam int BIT_TM_LO = 8;
   localparam int BIT_OFF = 7;
   localparam logic [13:0] MIDSCALE = 14'h2000;
   localparam logic [13:0] CODE_MAX = 14'h3fff;
   localparam logic [13:0] CODE_MIN = 14'h0000;
   localparam logic [14:0] SPAN_MAX = 15'h3fff;
   typedef enum logic [2:0] {
      TM_NORMAL = 3'h0, TM_BOTH_NEG = 3'h1, TM_HALF_NEG = 3'h2, TM_POS_NEG = 3'h3,
      TM_NORMAL2 = 3'h4, TM_BOTH_POS = 3'h5, TM_NEG_HALF = 3'h6, TM_NEG_POS = 3'h7
   } ahcp_tm_t;
endpackage : ahcp_pkg
`default_nettype wire

// [ahcp_top.sv]
`default_nettype none
module ahcp_top
   import ahcp_pkg::*;
#(
   parameter int PIPE = PIPE_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Host bus
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic csN,
   input wire logic wrN,
   input wire logic oeN,
   input wire logic [DATA_W-1:0] busDin,
   output logic [DATA_W-1:0] busDout,
   output logic busOeN,
   // Converter core, one sample per clock enable
   input wire logic sampleEn,
   input wire logic signed [DATA_W:0] diffIn,
   // Analog control
   output logic [GAIN_W-1:0] gainStage,
   output logic bandgapPinExt,
   output logic powerDown,
   output logic [2:0] testModeSelect,
   output logic testActive,
   output logic outOfRangeFlag
);
   logic [DATA_W-1:0] gain_q, offset_q, ctrl_q;
   logic [DATA_W-1:0] code_q [PIPE];
   logic ovr_q [PIPE];
   logic [DATA_W-1:0] rawCode, corrCode, readMux, result_q;
   localparam int TM_W = $bits(ahcp_tm_t);
   logic overRange, hostWrite, hostRead;
   logic hiSide, loSide, selGain, selOffset, selControl;
   ahcp_tm_t tmSel;

   // Upper span end; the top code is one LSB short of the positive reference
   function automatic logic aboveSpan(input logic signed [DATA_W:0] d);
      aboveSpan = d > ($signed({1'b0, SPAN_MAX}) >>> 1);
   endfunction : aboveSpan

   // Lower span end sits exactly at the negated reference
   function automatic logic belowSpan(input logic signed [DATA_W:0] d);
      belowSpan = d < -($signed({1'b0, MIDSCALE}));
   endfunction : belowSpan

   // Register address match, shared by the write and read paths
   function automatic logic isAddr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      isAddr = a == r;
   endfunction : isAddr

   assign hostWrite = !csN && !wrN;
   assign hostRead = !csN && !oeN;
   assign selGain = isAddr(busAddr, ADDR_GAIN);
   assign selOffset = isAddr(busAddr, ADDR_OFFSET);
   assign selControl = isAddr(busAddr, ADDR_CONTROL);
   assign tmSel = ahcp_tm_t'(ctrl_q[BIT_TM_LO +: TM_W]);

   // Quantise the difference, span maps 0..16383, zero to midscale
   assign hiSide = aboveSpan(diffIn);
   assign loSide = belowSpan(diffIn);
   assign overRange = hiSide || loSide;
   // Both ends saturate, so an overdriven input never folds back
   assign rawCode = loSide ? CODE_MIN
      : hiSide ? CODE_MAX
      : DATA_W'(diffIn + $signed({1'b0, MIDSCALE}));

   // Settings sampled at the conversion entry only
   ahcp_corrector uCorr (
      .rawCode(rawCode),
      .offsetVal(offset_q[OFFS_W-1:0]),
      .offDisable(ctrl_q[BIT_OFF]),
      .twosFmt(ctrl_q[BIT_FOR]),
      .outCode(corrCode)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gain_q <= RESET_VAL;
         offset_q <= RESET_VAL;
         ctrl_q <= RESET_VAL;
      end else if (hostWrite) begin
         // The result address is read only, a write there is dropped
         if (selGain) gain_q <= busDin;
         if (selOffset) offset_q <= busDin;
         if (selControl) ctrl_q <= busDin;
      end
   end

   // Data and flag travel the same stages
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < PIPE; i++) begin
            code_q[i] <= RESET_VAL;
            ovr_q[i] <= 1'b0;
         end
      end else if (sampleEn) begin
         code_q[0] <= corrCode;
         ovr_q[0] <= overRange;
         for (int i = 1; i < PIPE; i++) begin
            code_q[i] <= code_q[i-1];
            ovr_q[i] <= ovr_q[i-1];
         end
      end
   end

   assign readMux = selGain ? gain_q
      : selOffset ? offset_q
      : selControl ? ctrl_q : code_q[PIPE-1];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         result_q <= RESET_VAL;
         busOeN <= 1'b1;
         gainStage <= '0;
         bandgapPinExt <= 1'b0;
         powerDown <= 1'b0;
         testModeSelect <= '0;
         testActive <= 1'b0;
         outOfRangeFlag <= 1'b0;
      end else begin
         result_q <= readMux;
         busOeN <= !hostRead;
         gainStage <= gain_q[GAIN_W-1:0];
         bandgapPinExt <= ctrl_q[BIT_REF];
         powerDown <= ctrl_q[BIT_PWD];
         testModeSelect <= tmSel;
         testActive <= !(tmSel == TM_NORMAL || tmSel == TM_NORMAL2);
         outOfRangeFlag <= ovr_q[PIPE-1];
      end
   end
   assign busDout = result_q;

   a_oe_follow: assert property (@(posedge clk_sys) disable iff (rst)
      !csN && !oeN |=> !busOeN) else $error("bus not driven");
   a_oe_release: assert property (@(posedge clk_sys) disable iff (rst)
      (csN || oeN) |=> busOeN) else $error("bus driven while off");
   a_ref_bit: assert property (@(posedge clk_sys) disable iff (rst)
      hostWrite && busAddr == ADDR_CONTROL |=> ##1 bandgapPinExt == $past(busDin[BIT_REF], 2))
      else $error("ref select wrong");
   a_gain_set: assert property (@(posedge clk_sys) disable iff (rst)
      hostWrite && busAddr == ADDR_GAIN |=> ##1 gainStage == $past(busDin[GAIN_W-1:0], 2))
      else $error("gain wrong");
   a_test_norm: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_q[BIT_TM_LO +: TM_W-1] == '0 |=> !testActive) else $error("test mode on");
   a_test_on: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_q[BIT_TM_LO +: TM_W-1] != '0 |=> testActive) else $error("test mode off");
   a_ovr_stage: assert property (@(posedge clk_sys) disable iff (rst)
      sampleEn && overRange |=> ovr_q[0]) else $error("flag lost");
   a_zero_code: assert property (@(posedge clk_sys) disable iff (rst)
      diffIn == 0 |-> rawCode == MIDSCALE) else $error("zero code wrong");
   a_clamp_hi: assert property (@(posedge clk_sys) disable iff (rst)
      !ctrl_q[BIT_FOR] && rawCode == CODE_MAX && !ctrl_q[BIT_OFF] && !offset_q[OFFS_W-1]
      |-> corrCode == CODE_MAX) else $error("no clamp");
   a_off_dis: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_q[BIT_OFF] && !ctrl_q[BIT_FOR] |-> corrCode == rawCode)
      else $error("offset applied while disabled");
   a_pwr_bit: assert property (@(posedge clk_sys) disable iff (rst)
      hostWrite && selControl |=> ##1 powerDown == $past(busDin[BIT_PWD], 2))
      else $error("power down select wrong");
   a_addr0_ro: assert property (@(posedge clk_sys) disable iff (rst)
      hostWrite && isAddr(busAddr, ADDR_RESULT)
      |=> $stable(ctrl_q) && $stable(gain_q) && $stable(offset_q))
      else $error("write to result address took effect");
   a_pipe_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !sampleEn |=> $stable(code_q[PIPE-1]) && $stable(ovr_q[PIPE-1]))
      else $error("pipeline moved without a sample");
   a_pipe_step: assert property (@(posedge clk_sys) disable iff (rst)
      sampleEn |=> code_q[PIPE-1] == $past(code_q[PIPE-2])
      && ovr_q[PIPE-1] == $past(ovr_q[PIPE-2]))
      else $error("flag and data stages out of step");
   a_flag_out: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> outOfRangeFlag == $past(ovr_q[PIPE-1]))
      else $error("flag output not aligned");
   a_ovr_clear: assert property (@(posedge clk_sys) disable iff (rst)
      sampleEn && !overRange |=> !ovr_q[0]) else $error("false range flag");
   a_fmt_mid: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_q[BIT_FOR] && ctrl_q[BIT_OFF] && rawCode == MIDSCALE |-> corrCode == '0)
      else $error("twos complement zero wrong");
   a_off_mid: assert property (@(posedge clk_sys) disable iff (rst)
      !ctrl_q[BIT_OFF] && !ctrl_q[BIT_FOR] && rawCode == MIDSCALE
      |-> corrCode == MIDSCALE
      + {{(DATA_W-OFFS_W){offset_q[OFFS_W-1]}}, offset_q[OFFS_W-1:0]})
      else $error("offset not added at midscale");
   a_clamp_lo: assert property (@(posedge clk_sys) disable iff (rst)
      !ctrl_q[BIT_FOR] && rawCode == CODE_MIN && !ctrl_q[BIT_OFF] && offset_q[OFFS_W-1]
      |-> corrCode == CODE_MIN) else $error("no clamp at bottom");
   a_tm_out: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> testModeSelect == $past(ctrl_q[BIT_TM_LO +: TM_W]))
      else $error("test mode select wrong");
   a_rd_gain: assert property (@(posedge clk_sys) disable iff (rst)
      hostRead && selGain |=> busDout == $past(gain_q))
      else $error("gain read back wrong");
   a_rd_ctrl: assert property (@(posedge clk_sys) disable iff (rst)
      hostRead && selControl |=> busDout == $past(ctrl_q))
      else $error("control read back wrong");
   a_rd_offs: assert property (@(posedge clk_sys) disable iff (rst)
      hostRead && selOffset |=> busDout == $past(offset_q))
      else $error("offset read back wrong");
   // Scenarios the bench is expected to reach
   c_write_ctrl: cover property (@(posedge clk_sys) hostWrite && busAddr == ADDR_CONTROL);
   c_read_res: cover property (@(posedge clk_sys) hostRead && busAddr == ADDR_RESULT);
   c_ovr: cover property (@(posedge clk_sys) outOfRangeFlag);
   c_test: cover property (@(posedge clk_sys) testActive);
   c_offset: cover property (@(posedge clk_sys)
      sampleEn && !ctrl_q[BIT_OFF] && offset_q != '0);
endmodule : ahcp_top
`default_nettype wire
